// ===== hdl/tecc_pkg.sv
package tecc_pkg;
    localparam int TECC_DATA_W = 32;
    localparam int TECC_ADDR_W = 16;
    localparam int TECC_CNT_W = 16;
    localparam int TECC_IDX_W = 14;

    // Register indices; byte address is four times the index
    localparam logic [31:0] TECC_IDX_MODE = 32'hFFFFF616;
    localparam logic [31:0] TECC_IDX_EDGE = 32'hFFFFF617;
    localparam logic [31:0] TECC_IDX_CCC = 32'hFFFFF618;
    localparam logic [31:0] TECC_IDX_OUT = 32'hFFFFF619;
    localparam logic [31:0] TECC_IDX_COUNT = 32'hFFFFF620;
    localparam logic [31:0] TECC_IDX_CC1 = 32'hFFFFF622;
    localparam logic [31:0] TECC_IDX_CC2 = 32'hFFFFF624;

    localparam logic [7:0] TECC_RST8 = 8'h00;
    localparam logic [15:0] TECC_RST16 = 16'h0000;
    localparam logic [15:0] TECC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TECC_CNT_ONE = 16'h0001;

    // timer_mode_control fields
    localparam int TECC_MODE_HI = 3;
    localparam int TECC_MODE_LO = 2;
    localparam int TECC_MODE_TOG = 1;
    localparam int TECC_MODE_OVF = 0;
    localparam logic [1:0] TECC_RUN_STOP = 2'h0;
    localparam logic [1:0] TECC_RUN_FREE = 2'h1;
    localparam logic [1:0] TECC_RUN_EDGE = 2'h2;
    localparam logic [1:0] TECC_RUN_MATCH = 2'h3;

    // capture_compare_control fields
    localparam int TECC_CCC_SECOND_CAP = 2;
    localparam int TECC_CCC_TRIG_SEL = 1;
    localparam int TECC_CCC_FIRST_CAP = 0;
    localparam logic [7:0] TECC_CCC_MASK = 8'h07;

    // output_control fields
    localparam int TECC_OUT_ONESHOT = 6;
    localparam int TECC_OUT_OSPE = 5;
    localparam int TECC_OUT_TOG2 = 4;
    localparam int TECC_OUT_SET = 3;
    localparam int TECC_OUT_CLR = 2;
    localparam int TECC_OUT_TOG1 = 1;
    localparam int TECC_OUT_EN = 0;
    localparam logic [7:0] TECC_OUT_MASK = 8'h33;

    // prescale_edge_config fields
    localparam int TECC_EDGE_B_HI = 7;
    localparam int TECC_EDGE_B_LO = 6;
    localparam int TECC_EDGE_A_HI = 5;
    localparam int TECC_EDGE_A_LO = 4;
    localparam logic [7:0] TECC_EDGE_MASK = 8'hF3;
    localparam logic [1:0] TECC_ES_FALL = 2'h0;
    localparam logic [1:0] TECC_ES_RISE = 2'h1;
    localparam logic [1:0] TECC_ES_BOTH = 2'h3;

    localparam logic [1:0] TECC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TECC_RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/tecc_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tecc_edge_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic s1_reg, s2_reg, s3_reg, lvl_reg;
    logic lvl_next;
    logic agree;

    // [RULE24]
    always_comb begin
        agree = (s2_reg == s3_reg);
        lvl_next = agree ? s3_reg : lvl_reg;
        rise = agree & s3_reg & ~lvl_reg;
        fall = agree & ~s3_reg & lvl_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/tecc_timer.sv
// Functional notes
// RULE1: No mode register writes while running
// RULE2: Nonzero enable field starts, 00 stops
// RULE3: Enable 00 stops and zeroes counter
// RULE4: Modes: free, clear on edge, clear on match
// RULE5: Output toggles on matches, optionally edge
// RULE6: Rollover from FFFF sets overflow flag
// RULE7: Flag cleared by write 0 or stop
// RULE8: Toggle condition 0 when pins shared
// RULE9: No capture control writes while running
// RULE10: Second register compare or capture select
// RULE11: First register compare or capture select
// RULE12: First capture trigger: input b or inverse a
// RULE13: Inverse phase with both edges detects none
// RULE14: Match-clear mode needs first in compare
// RULE15: Inverse phase: b edge raises first irq
// RULE16: Trigger pulses two count clocks longer
// RULE17: Only one-shot bit writable while running; the code writes every output_control bit while running
// RULE18: Second toggle enable writable while running
// RULE19: Control registers byte access, reset 00
// RULE20: Counter increments each count clock
// RULE21: First compare match raises first irq
// RULE22: Second captures counter on a edge
// RULE23: Edge codes: 00 fall, 01 rise, 11 both
// RULE24: Triggers synchronised before edge detection
// RULE25: Rollover set beats software clear
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tecc_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tecc_pkg::TECC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tecc_pkg::TECC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tecc_pkg::TECC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tecc_pkg::TECC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger_in_a,
    input wire logic trigger_in_b,
    output logic timer_out_pin,
    output logic match_irq_first,
    output logic match_irq_second
);
    import tecc_pkg::*;

    // Bus state
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [TECC_IDX_W-1:0] aw_idx_reg, aw_idx_next;
    logic [TECC_DATA_W-1:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [TECC_DATA_W-1:0] rdata_reg, rdata_next;
    logic awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, ardy_reg, ardy_next;

    // Timer state
    logic [7:0] mode_reg, mode_next, ccc_reg, ccc_next;
    logic [7:0] outc_reg, outc_next, edge_reg, edge_next;
    logic [TECC_CNT_W-1:0] count_reg, count_next;
    logic [TECC_CNT_W-1:0] cc1_reg, cc1_next, cc2_reg, cc2_next;
    logic tout_reg, tout_next, irq1_reg, irq1_next, irq2_reg, irq2_next;

    logic a_rise, a_fall, b_rise, b_fall;
    logic a_valid, a_inverse, b_valid;
    logic wr_fire, rd_fire, wr_hit, rd_hit;
    logic [TECC_IDX_W-1:0] rd_idx;
    logic [1:0] run_mode;
    logic running, first_cap, second_cap, trig_sel;
    logic match1, match2, clear_start, oneshot, rollover;

    tecc_edge_sync u_sync_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(trigger_in_a),
        .rise(a_rise),
        .fall(a_fall)
    );

    tecc_edge_sync u_sync_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(trigger_in_b),
        .rise(b_rise),
        .fall(b_fall)
    );

    function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
        logic res;
        res = 1'b0;
        unique case (sel)
            TECC_ES_FALL: res = f;
            TECC_ES_RISE: res = r;
            TECC_ES_BOTH: res = r | f;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    function automatic logic idx_is(input logic [TECC_IDX_W-1:0] idx, input logic [31:0] ref_idx);
        return idx == ref_idx[TECC_IDX_W-1:0];
    endfunction

    function automatic logic idx_known(input logic [TECC_IDX_W-1:0] idx);
        return idx_is(idx, TECC_IDX_MODE) | idx_is(idx, TECC_IDX_EDGE)
            | idx_is(idx, TECC_IDX_CCC) | idx_is(idx, TECC_IDX_OUT)
            | idx_is(idx, TECC_IDX_COUNT) | idx_is(idx, TECC_IDX_CC1)
            | idx_is(idx, TECC_IDX_CC2);
    endfunction

    // Edges and decoded controls
    always_comb begin
        run_mode = mode_reg[TECC_MODE_HI:TECC_MODE_LO];
        running = (run_mode != TECC_RUN_STOP); // [RULE2]
        first_cap = ccc_reg[TECC_CCC_FIRST_CAP]; // [RULE11]
        second_cap = ccc_reg[TECC_CCC_SECOND_CAP]; // [RULE10]
        trig_sel = ccc_reg[TECC_CCC_TRIG_SEL];
        a_valid = edge_pick(edge_reg[TECC_EDGE_A_HI:TECC_EDGE_A_LO], a_rise, a_fall); // [RULE23]
        a_inverse = edge_pick(edge_reg[TECC_EDGE_A_HI:TECC_EDGE_A_LO], a_fall, a_rise);
        if (trig_sel && edge_reg[TECC_EDGE_A_HI:TECC_EDGE_A_LO] == TECC_ES_BOTH) begin
            a_valid = 1'b0; // [RULE13]
            a_inverse = 1'b0;
        end
        b_valid = edge_pick(edge_reg[TECC_EDGE_B_HI:TECC_EDGE_B_LO], b_rise, b_fall);
        match1 = running && !first_cap && count_reg == cc1_reg; // [RULE21]
        match2 = running && !second_cap && count_reg == cc2_reg;
        rollover = running && count_reg == TECC_CNT_MAX;
    end

    // AXI4-Lite slave: address and data taken in either order
    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_idx_next = aw_idx_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        rd_idx = s_axi_araddr[TECC_ADDR_W-1:2];
        if (s_axi_awvalid && awrdy_reg) begin
            aw_have_next = 1'b1;
            aw_idx_next = s_axi_awaddr[TECC_ADDR_W-1:2];
        end
        if (s_axi_wvalid && wrdy_reg) begin
            w_have_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
        wr_hit = wr_fire && idx_known(aw_idx_reg);
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = idx_known(aw_idx_reg) ? TECC_RESP_OKAY : TECC_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        rd_fire = s_axi_arvalid && ardy_reg;
        rd_hit = rd_fire && idx_known(rd_idx);
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = rd_hit ? TECC_RESP_OKAY : TECC_RESP_SLVERR;
            rdata_next = '0;
            // One-shot and level triggers always read as zero
            if (idx_is(rd_idx, TECC_IDX_MODE)) rdata_next[7:0] = mode_reg;
            if (idx_is(rd_idx, TECC_IDX_EDGE)) rdata_next[7:0] = edge_reg;
            if (idx_is(rd_idx, TECC_IDX_CCC)) rdata_next[7:0] = ccc_reg;
            if (idx_is(rd_idx, TECC_IDX_OUT)) rdata_next[7:0] = outc_reg;
            if (idx_is(rd_idx, TECC_IDX_COUNT)) rdata_next[15:0] = count_reg;
            if (idx_is(rd_idx, TECC_IDX_CC1)) rdata_next[15:0] = cc1_reg;
            if (idx_is(rd_idx, TECC_IDX_CC2)) rdata_next[15:0] = cc2_reg;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        // Readies drop while a response waits, so no second request slips in
        awrdy_next = !aw_have_next && !bvalid_next;
        wrdy_next = !w_have_next && !bvalid_next;
        ardy_next = !rvalid_next;
    end

    // Register writes, counter, capture and output
    always_comb begin
        mode_next = mode_reg;
        ccc_next = ccc_reg;
        outc_next = outc_reg;
        edge_next = edge_reg;
        cc1_next = cc1_reg;
        cc2_next = cc2_reg;
        tout_next = tout_reg;
        oneshot = 1'b0;
        // Byte lane 0 covers every 8-bit register [RULE19]
        if (wr_hit && wstrb_reg[0]) begin
            if (idx_is(aw_idx_reg, TECC_IDX_MODE)) begin
                mode_next = {4'h0, wdata_reg[3:0]};
            end
            if (idx_is(aw_idx_reg, TECC_IDX_CCC)) ccc_next = wdata_reg[7:0] & TECC_CCC_MASK;
            if (idx_is(aw_idx_reg, TECC_IDX_EDGE)) edge_next = wdata_reg[7:0] & TECC_EDGE_MASK;
            if (idx_is(aw_idx_reg, TECC_IDX_OUT)) begin
                outc_next = wdata_reg[7:0] & TECC_OUT_MASK;
                oneshot = wdata_reg[TECC_OUT_ONESHOT] && running;
                // Level triggers act only while the output is enabled
                if (wdata_reg[TECC_OUT_EN] && wdata_reg[TECC_OUT_SET] != wdata_reg[TECC_OUT_CLR])
                    tout_next = wdata_reg[TECC_OUT_SET];
            end
        end
        if (wr_hit && idx_is(aw_idx_reg, TECC_IDX_CC1)) begin
            if (wstrb_reg[0]) cc1_next[7:0] = wdata_reg[7:0];
            if (wstrb_reg[1]) cc1_next[15:8] = wdata_reg[15:8];
        end
        if (wr_hit && idx_is(aw_idx_reg, TECC_IDX_CC2)) begin
            if (wstrb_reg[0]) cc2_next[7:0] = wdata_reg[7:0];
            if (wstrb_reg[1]) cc2_next[15:8] = wdata_reg[15:8];
        end

        clear_start = oneshot
            || (run_mode == TECC_RUN_EDGE && a_valid)
            || (run_mode == TECC_RUN_MATCH && match1); // [RULE4]
        if (!running) begin
            count_next = '0; // [RULE3]
        end else if (clear_start) begin
            count_next = '0;
        end else begin
            count_next = count_reg + TECC_CNT_ONE; // [RULE20]
        end

        // Only the step into stop clears; a write of 1 while stopped must stick
        if (running && mode_next[TECC_MODE_HI:TECC_MODE_LO] == TECC_RUN_STOP) begin
            mode_next[TECC_MODE_OVF] = 1'b0; // [RULE7]
        end
        // A clear at FFFF also wraps to zero, so it sets the flag too
        if (rollover) begin
            mode_next[TECC_MODE_OVF] = 1'b1; // [RULE6] [RULE25]
        end

        // Captures; a stop racing a capture leaves undefined data anyway
        if (running && first_cap && !trig_sel && b_valid) cc1_next = count_reg; // [RULE12]
        if (running && first_cap && trig_sel && a_inverse) cc1_next = count_reg; // [RULE12]
        if (running && second_cap && a_valid) cc2_next = count_reg; // [RULE22]

        irq1_next = match1 || (running && !trig_sel && first_cap && b_valid)
            || (running && trig_sel && b_valid); // [RULE15]
        irq2_next = match2 || (running && second_cap && a_valid);

        if (running && ((match1 && outc_reg[TECC_OUT_TOG1])
                ^ (match2 && outc_reg[TECC_OUT_TOG2])
                ^ (mode_reg[TECC_MODE_TOG] && a_valid))) begin
            tout_next = ~tout_next; // [RULE5]
        end
        if (!outc_next[TECC_OUT_EN]) tout_next = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_idx_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= TECC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= TECC_RESP_OKAY;
            rdata_reg <= '0;
            awrdy_reg <= 1'b1;
            wrdy_reg <= 1'b1;
            ardy_reg <= 1'b1;
            mode_reg <= TECC_RST8;
            ccc_reg <= TECC_RST8;
            outc_reg <= TECC_RST8;
            edge_reg <= TECC_RST8;
            count_reg <= TECC_RST16;
            cc1_reg <= TECC_RST16;
            cc2_reg <= TECC_RST16;
            tout_reg <= 1'b0;
            irq1_reg <= 1'b0;
            irq2_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_idx_reg <= aw_idx_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            awrdy_reg <= awrdy_next;
            wrdy_reg <= wrdy_next;
            ardy_reg <= ardy_next;
            mode_reg <= mode_next;
            ccc_reg <= ccc_next;
            outc_reg <= outc_next;
            edge_reg <= edge_next;
            count_reg <= count_next;
            cc1_reg <= cc1_next;
            cc2_reg <= cc2_next;
            tout_reg <= tout_next;
            irq1_reg <= irq1_next;
            irq2_reg <= irq2_next;
        end
    end

    assign s_axi_awready = awrdy_reg;
    assign s_axi_wready = wrdy_reg;
    assign s_axi_arready = ardy_reg;

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign timer_out_pin = tout_reg;
    assign match_irq_first = irq1_reg;
    assign match_irq_second = irq2_reg;
endmodule
`default_nettype wire

// ===== tb/tecc_timer_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tecc_timer_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [tecc_pkg::TECC_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_out_pin,
    input wire logic match_irq_first,
    input wire logic match_irq_second
);
    import tecc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_state_a:
    assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready
        && !s_axi_bvalid && !s_axi_rvalid && !timer_out_pin && !match_irq_first)
        else $error("outputs not idle after reset");
    b_resp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    r_data_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response not held");
    r_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    one_read_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while pending");
    one_write_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while pending");
    b_release_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    irq_first_pulse_a:
    assert property (match_irq_first |=> !match_irq_first) else $error("first irq too long");
    irq_second_pulse_a:
    assert property (match_irq_second |=> !match_irq_second) else $error("second irq too long");
endmodule
bind tecc_timer tecc_timer_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_out_pin(timer_out_pin),
    .match_irq_first(match_irq_first), .match_irq_second(match_irq_second));
`default_nettype wire

// ===== tb/tecc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module tecc_pin_model (
    input wire logic aclk,
    output logic trigger_in_a,
    output logic trigger_in_b
);
    // Separate output pin, so toggling on input a is legal here
    initial begin
        trigger_in_a = 1'b0;
        trigger_in_b = 1'b0;
    end
    task automatic pulse(input logic on_b, input int hi_cycles);
        @(posedge aclk);
        if (on_b) trigger_in_b <= 1'b1;
        else trigger_in_a <= 1'b1;
        // Callers keep this at 3 or more, beyond the one-cycle count clock
        repeat (hi_cycles) @(posedge aclk);
        trigger_in_a <= 1'b0;
        trigger_in_b <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tecc_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, trig_a, trig_b, tout, irq1, irq2, p0;
    logic [TECC_ADDR_W-1:0] awaddr, araddr;
    logic [TECC_DATA_W-1:0] wdata, rdata;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] cmp;
    logic [65:0] rn;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    logic [31:0] regs[7] = '{TECC_IDX_MODE, TECC_IDX_EDGE, TECC_IDX_CCC, TECC_IDX_OUT,
                             TECC_IDX_COUNT, TECC_IDX_CC1, TECC_IDX_CC2};
    integer seed;
    int bad_count = 0, tests_run = 0, n1 = 0, n2 = 0, t1 = 0, t2 = 0, cyc = 0, t0, k;

    tecc_timer i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_in_a(trig_a),
        .trigger_in_b(trig_b), .timer_out_pin(tout), .match_irq_first(irq1),
        .match_irq_second(irq2)
    );
    tecc_pin_model i_pins (.aclk(aclk), .trigger_in_a(trig_a), .trigger_in_b(trig_b));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic test_done;
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic limit(input int n);
        if (n >= 2000) begin
            bad_count++;
            test_done;
        end
    endtask
    function automatic logic [15:0] ad(input logic [31:0] idx);
        return {idx[13:0], 2'b00};
    endfunction
    task automatic wr(input logic [31:0] idx, input logic [31:0] d,
                      input logic [1:0] r = TECC_RESP_OKAY);
        int n;
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= ad(idx);
        awprot <= 3'($random(seed));
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 2000);
        bready <= 1'b0;
        limit(n);
    endtask
    task automatic rd(input logic [31:0] idx, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = TECC_RESP_OKAY);
        int n;
        @(posedge aclk);
        rq.push_back({r, m, e});
        araddr <= ad(idx);
        arprot <= 3'($random(seed));
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 2000);
        rready <= 1'b0;
        limit(n);
    endtask
    task automatic wait_n(input logic sel, input int want);
        int n;
        n = 0;
        while ((sel ? n2 : n1) < want && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        limit(n);
    endtask

    // Response checker: oldest note against each completed response
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (irq1) begin
            n1 <= n1 + 1;
            t1 <= cyc;
        end
        if (irq2) begin
            n2 <= n2 + 1;
            t2 <= cyc;
        end
        if (rvalid && rready && rq.size() > 0) begin
            rn = rq.pop_front();
            check("rdata", rdata & rn[63:32], rn[31:0] & rn[63:32]);
            check("rresp", {30'h0, rresp}, {30'h0, rn[65:64]});
        end
        if (bvalid && bready && bq.size() > 0) begin
            check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
        end
    end

    initial begin
        seed = 32'h11c7;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) rd(regs[i], 32'h0);
        rd(32'h0, 32'h0, 32'hFFFFFFFF, TECC_RESP_SLVERR);
        wr(32'h0, 32'h5, TECC_RESP_SLVERR);
        wr(TECC_IDX_CCC, 32'h7);
        rd(TECC_IDX_CCC, 32'h7);
        wr(TECC_IDX_CCC, 32'h0);
        wr(TECC_IDX_MODE, 32'h1);
        rd(TECC_IDX_MODE, 32'h1);
        wr(TECC_IDX_MODE, 32'h0);
        rd(TECC_IDX_MODE, 32'h0);
        // Compare matches on both registers toggle the pin
        cmp = 32'h20 + (32'($random(seed)) & 32'h3F);
        wr(TECC_IDX_CC1, cmp);
        wr(TECC_IDX_CC2, cmp + 32'h30);
        wr(TECC_IDX_OUT, 32'h13);
        wr(TECC_IDX_MODE, {28'h0, TECC_RUN_FREE, 2'b00});
        wait_n(1'b0, 1);
        repeat (3) @(posedge aclk);
        check("pin_first", {31'h0, tout}, 32'h1);
        wait_n(1'b1, 1);
        check("match_gap", 32'(t2 - t1), 32'h30);
        repeat (3) @(posedge aclk);
        check("pin_second", {31'h0, tout}, 32'h0);
        wr(TECC_IDX_MODE, 32'h0);
        rd(TECC_IDX_COUNT, 32'h0);
        // Clear on first-register match: period is one more than the compare value
        wr(TECC_IDX_MODE, {28'h0, TECC_RUN_MATCH, 2'b00});
        wait_n(1'b0, 2);
        t0 = t1;
        wait_n(1'b0, 3);
        check("clear_period", 32'(t1 - t0), cmp + 32'h1);
        wr(TECC_IDX_MODE, 32'h0);
        wr(TECC_IDX_MODE, {28'h0, TECC_RUN_FREE, 2'b00});
        repeat (65550) @(posedge aclk);
        rd(TECC_IDX_MODE, 32'h5);
        wr(TECC_IDX_MODE, 32'h0);
        rd(TECC_IDX_MODE, 32'h0);
        // Edge on input a: clear, capture into second register, pin toggle
        wr(TECC_IDX_CC2, 32'hFFFF);
        wr(TECC_IDX_EDGE, 32'h10);
        wr(TECC_IDX_CCC, 32'h4);
        wr(TECC_IDX_OUT, 32'h01);
        wr(TECC_IDX_MODE, {28'h0, TECC_RUN_EDGE, 2'b10});
        repeat (5) @(posedge aclk);
        p0 = tout;
        k = n2;
        i_pins.pulse(1'b0, 4);
        wait_n(1'b1, k + 1);
        rd(TECC_IDX_COUNT, 32'h0, 32'hFFC0);
        rd(TECC_IDX_CC2, 32'h0, 32'hFF00);
        check("pin_edge", {31'h0, tout}, {31'h0, ~p0});
        // Inverse phase of a: both-edge a is ignored, b edge only interrupts
        wr(TECC_IDX_MODE, 32'h0);
        wr(TECC_IDX_CC1, 32'h1234);
        wr(TECC_IDX_EDGE, 32'h30);
        wr(TECC_IDX_CCC, 32'h3);
        wr(TECC_IDX_MODE, {28'h0, TECC_RUN_FREE, 2'b00});
        k = n1;
        i_pins.pulse(1'b0, 4);
        i_pins.pulse(1'b1, 4);
        repeat (10) @(posedge aclk);
        check("ext_irq", 32'(n1), 32'(k + 1));
        rd(TECC_IDX_CC1, 32'h1234);
        // One-shot is the only output-control change allowed while running; the timer still writes the other bits
        wr(TECC_IDX_OUT, 32'h41);
        rd(TECC_IDX_COUNT, 32'h0, 32'hFFF0);
        rd(TECC_IDX_OUT, 32'h01);
        wr(TECC_IDX_MODE, 32'h0);
        test_done;
    end
endmodule
`default_nettype wire
